/* design/pac_pixel_array_control.sv */
`timescale 1ns/100ps
module pac_pixel_array_control (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Control pins from the camera controller
  input wire logic fullResetCtrl,
  input wire logic partial_reset_ctrl,
  input wire logic prechargeCtrlN,
  input wire logic sampleCtrlN,
  input wire logic storage_boost_ctrl,
  input wire logic colClk,
  input wire logic rowClk,
  // Internal pixel drives
  output logic pixelReset,
  output logic fullLevelSel,
  output logic partial_reset_supply,
  output logic storageHigh,
  output logic sfLoad,
  output logic sampleXfer,
  output logic integrating,
  // Output stage configuration and flush status
  output logic [6:0] dcRefLevel,
  output logic dualOutput,
  output logic flushDone
);
  logic [6:0] pinSync;
  logic fullRst;
  logic partRst;
  logic prechOn;
  logic sampleOn;
  logic boostHigh;
  logic colSync;
  logic rowSync;
  logic colPrev_q;
  logic rowPrev_q;
  logic [pac_pkg::FLUSHW:0] colCnt_q;
  logic [pac_pkg::FLUSHW:0] rowCnt_q;
  logic [pac_pkg::FLUSHW:0] colCnt_d;
  logic [pac_pkg::FLUSHW:0] rowCnt_d;
  logic [31:0] integCnt_q;
  logic [31:0] lastInteg_q;
  logic [6:0] dcRef_q;
  logic dualOut_q;
  pac_pkg::pac_rstsel_e rstSel;
  logic access;
  logic [31:0] statusWord;

  // All control pins come from another chip, so they cross two flops first.
  pac_sync #(.W(7)) u_sync (
    .mclk(mclk),
    .srst(srst),
    .async({fullResetCtrl, partial_reset_ctrl, prechargeCtrlN, sampleCtrlN,
      storage_boost_ctrl, colClk, rowClk}),
    .synced(pinSync)
  );

  assign fullRst = pinSync[6];
  assign partRst = pinSync[5];
  assign prechOn = ~pinSync[4];
  assign sampleOn = ~pinSync[3];
  // Boost is active high at the pin; the offset is high when the pin reads one.
  assign boostHigh = pinSync[2];
  assign colSync = pinSync[1];
  assign rowSync = pinSync[0];

  // Full reset dominates so a partial pulse never lowers a full reset.
  always_comb
  begin
    if (fullRst)
    begin
      rstSel = pac_pkg::PAC_RST_FULL;
    end
    else if (partRst)
    begin
      rstSel = pac_pkg::PAC_RST_PARTIAL;
    end
    else
    begin
      rstSel = pac_pkg::PAC_RST_NONE;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pixelReset <= 1'b0;
      fullLevelSel <= 1'b0;
      partial_reset_supply <= 1'b0;
    end
    else
    begin
      pixelReset <= (rstSel != pac_pkg::PAC_RST_NONE);
      fullLevelSel <= (rstSel == pac_pkg::PAC_RST_FULL);
      partial_reset_supply <= (rstSel == pac_pkg::PAC_RST_PARTIAL);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      storageHigh <= 1'b0;
      sfLoad <= 1'b0;
      sampleXfer <= 1'b0;
    end
    else
    begin
      storageHigh <= boostHigh;
      sfLoad <= prechOn;
      sampleXfer <= sampleOn;
    end
  end

  // Integration starts when full reset releases and ends at the sample rise.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      integrating <= 1'b0;
      integCnt_q <= '0;
      lastInteg_q <= '0;
    end
    else if (fullRst)
    begin
      integrating <= 1'b0;
      integCnt_q <= '0;
    end
    else if (pixelReset && fullLevelSel)
    begin
      integrating <= 1'b1;
      // Starts at one so the count covers every cycle from release up to the sample edge.
      integCnt_q <= 32'h1;
    end
    else if (integrating && sampleOn)
    begin
      integrating <= 1'b0;
      lastInteg_q <= integCnt_q;
    end
    else if (integrating && integCnt_q != '1)
    begin
      integCnt_q <= integCnt_q + 32'h1;
    end
  end

  // Counts the flush clocks; saturates so the flag stays set.
  always_comb
  begin
    colCnt_d = colCnt_q;
    rowCnt_d = rowCnt_q;
    if (colSync && !colPrev_q && colCnt_q < (pac_pkg::FLUSHW+1)'(pac_pkg::COLFLUSH))
    begin
      colCnt_d = colCnt_q + {{pac_pkg::FLUSHW{1'b0}}, 1'b1};
    end
    if (rowSync && !rowPrev_q && rowCnt_q < (pac_pkg::FLUSHW+1)'(pac_pkg::ROWFLUSH))
    begin
      rowCnt_d = rowCnt_q + {{pac_pkg::FLUSHW{1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      colPrev_q <= 1'b0;
      rowPrev_q <= 1'b0;
      colCnt_q <= '0;
      rowCnt_q <= '0;
      flushDone <= 1'b0;
    end
    else
    begin
      colPrev_q <= colSync;
      rowPrev_q <= rowSync;
      colCnt_q <= colCnt_d;
      rowCnt_q <= rowCnt_d;
      flushDone <= (colCnt_d == (pac_pkg::FLUSHW+1)'(pac_pkg::COLFLUSH)) &&
        (rowCnt_d == (pac_pkg::FLUSHW+1)'(pac_pkg::ROWFLUSH));
    end
  end

  // APB: zero wait states, writes take effect on the access cycle.
  assign access = psel && penable;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      dcRef_q <= pac_pkg::DCREF_RESET;
      dualOut_q <= pac_pkg::DUAL_OUT_RESET;
    end
    else if (access && pwrite && paddr == pac_pkg::CFG_ADDR)
    begin
      dcRef_q <= pwdata[pac_pkg::DCREF_LSB +: pac_pkg::DCREF_W];
      dualOut_q <= pwdata[pac_pkg::DUAL_OUT_BIT];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      dcRefLevel <= pac_pkg::DCREF_RESET;
      dualOutput <= pac_pkg::DUAL_OUT_RESET;
    end
    else
    begin
      dcRefLevel <= dcRef_q;
      dualOutput <= dualOut_q;
    end
  end

  always_comb
  begin
    statusWord = '0;
    statusWord[pac_pkg::ST_RESET] = pixelReset;
    statusWord[pac_pkg::ST_PARTIAL] = partial_reset_supply;
    statusWord[pac_pkg::ST_PRECH] = sfLoad;
    statusWord[pac_pkg::ST_SAMPLE] = sampleXfer;
    statusWord[pac_pkg::ST_BOOST] = storageHigh;
    statusWord[pac_pkg::ST_FULLLVL] = fullLevelSel;
    statusWord[pac_pkg::ST_INTEG] = integrating;
    statusWord[pac_pkg::ST_FLUSHED] = flushDone;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable)
      begin
        if (paddr == pac_pkg::CFG_ADDR)
        begin
          prdata <= {24'h000000, dualOut_q, dcRef_q};
        end
        else if (paddr == pac_pkg::STAT_ADDR)
        begin
          prdata <= statusWord;
        end
        else if (paddr == pac_pkg::CNT_ADDR)
        begin
          prdata <= lastInteg_q;
        end
        else
        begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  a_full_priority: assert property (@(posedge mclk) disable iff (srst)
    fullRst && partRst |=> pixelReset && fullLevelSel && !partial_reset_supply)
    else $error("full reset did not win over partial reset");
  a_partial_level: assert property (@(posedge mclk) disable iff (srst)
    !fullRst && partRst |=> partial_reset_supply && !fullLevelSel)
    else $error("partial reset level not selected");
  a_boost_level: assert property (@(posedge mclk) disable iff (srst)
    $changed(boostHigh) |=> storageHigh == $past(boostHigh))
    else $error("storage offset level does not follow boost input");
  a_precharge_load: assert property (@(posedge mclk) disable iff (srst)
    prechOn |=> sfLoad)
    else $error("source follower not loaded during precharge");
  a_sample_xfer: assert property (@(posedge mclk) disable iff (srst)
    !sampleOn |=> !sampleXfer)
    else $error("sample transfer active without sample");
  a_reset_hold: assert property (@(posedge mclk) disable iff (srst)
    fullRst |=> !integrating ##1 (!fullRst || !integrating))
    else $error("integrating while full reset held");
  a_integ_start: assert property (@(posedge mclk) disable iff (srst)
    $fell(fullRst) && !partRst && !sampleOn |=> integrating)
    else $error("integration did not start on reset release");
  a_integ_end: assert property (@(posedge mclk) disable iff (srst)
    integrating && sampleOn && !fullRst |=> !integrating)
    else $error("integration did not end at sample");
  a_dcref_write: assert property (@(posedge mclk) disable iff (srst)
    access && pwrite && paddr == pac_pkg::CFG_ADDR |=> ##1 dcRefLevel == $past(pwdata[6:0], 2))
    else $error("dc reference word not applied");
  a_dual_write: assert property (@(posedge mclk) disable iff (srst)
    access && pwrite && paddr == pac_pkg::CFG_ADDR |=> ##1 dualOutput == $past(pwdata[7], 2))
    else $error("output stage select not applied");
endmodule

/* shared/pac_pkg.sv */
package pac_pkg;
  // APB byte addresses of the configuration, status and integration count words.
  localparam logic [7:0] CFG_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;
  localparam logic [7:0] CNT_ADDR = 8'h08;
  // Field layout of the configuration word.
  localparam int DCREF_LSB = 0;
  localparam int DCREF_W = 7;
  localparam int DUAL_OUT_BIT = 7;
  localparam logic [6:0] DCREF_RESET = 7'h00;
  localparam logic DUAL_OUT_RESET = 1'b0;
  // Status word bit positions.
  localparam int ST_RESET = 0;
  localparam int ST_PARTIAL = 1;
  localparam int ST_PRECH = 2;
  localparam int ST_SAMPLE = 3;
  localparam int ST_BOOST = 4;
  localparam int ST_FULLLVL = 5;
  localparam int ST_INTEG = 6;
  localparam int ST_FLUSHED = 7;
  // Shift register flush lengths.
  localparam int COLFLUSH = 1024;
  localparam int ROWFLUSH = 2048;
  localparam int FLUSHW = 12;
  // Reset supply selection.
  typedef enum logic [1:0] {PAC_RST_NONE, PAC_RST_PARTIAL, PAC_RST_FULL} pac_rstsel_e;
endpackage

/* design/pac_sync.sv */
`timescale 1ns/100ps
// Two-stage synchroniser for a bundle of pin levels.
module pac_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Data
  input wire logic [W-1:0] async,
  output logic [W-1:0] synced
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      meta_q <= '0;
      synced <= '0;
    end
    else
    begin
      meta_q <= async;
      synced <= meta_q;
    end
  end
endmodule

/* verification/pac_ctrl_model.sv */
`timescale 1ns/100ps
// Behavioural camera controller that drives the sensor's pixel control pins.
module pac_ctrl_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Requested pin levels and flush status
  input wire logic [4:0] pinReq,
  output logic flushSent,
  // Sensor control pins
  output logic fullResetCtrl,
  output logic partial_reset_ctrl,
  output logic prechargeCtrlN,
  output logic sampleCtrlN,
  output logic storage_boost_ctrl,
  output logic colClk,
  output logic rowClk
);
  logic [11:0] colCnt_q;
  logic [11:0] rowCnt_q;

  // Clocking starts at once after reset so the sensor leaves its latch state early.
  // Each clock stands still low once its pulse count is reached.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      colClk <= 1'b0;
      rowClk <= 1'b0;
      colCnt_q <= 12'h000;
      rowCnt_q <= 12'h000;
    end
    else
    begin
      if (colCnt_q != 12'h400)
      begin
        colClk <= ~colClk;
        colCnt_q <= colCnt_q + {11'h000, colClk};
      end
      if (rowCnt_q != 12'h800)
      begin
        rowClk <= ~rowClk;
        rowCnt_q <= rowCnt_q + {11'h000, rowClk};
      end
    end
  end

  assign flushSent = (colCnt_q == 12'h400) && (rowCnt_q == 12'h800);

  // Resets and storage boost are active high; precharge and sample are active low.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      {storage_boost_ctrl, sampleCtrlN, prechargeCtrlN, partial_reset_ctrl, fullResetCtrl} <= 5'h1c;
    end
    else
    begin
      {storage_boost_ctrl, sampleCtrlN, prechargeCtrlN, partial_reset_ctrl, fullResetCtrl} <= pinReq;
    end
  end
endmodule

/* verification/testbench.sv */
`timescale 1ns/100ps
module testbench;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, flushSent, dualOutput, flushDone;
  logic fullResetCtrl, partial_reset_ctrl, prechargeCtrlN, sampleCtrlN;
  logic storage_boost_ctrl, colClk, rowClk;
  logic [6:0] dcRefLevel;
  logic [4:0] pinReq = 5'h1c;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  logic errQ[$];
  logic [31:0] d;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 13774;
  int i;

  always #12.5 mclk = ~mclk;

  pac_pixel_array_control pac_pixel_array_control_i (.mclk(mclk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fullResetCtrl(fullResetCtrl),
    .partial_reset_ctrl(partial_reset_ctrl), .prechargeCtrlN(prechargeCtrlN),
    .sampleCtrlN(sampleCtrlN), .storage_boost_ctrl(storage_boost_ctrl), .colClk(colClk),
    .rowClk(rowClk), .pixelReset(), .fullLevelSel(), .partial_reset_supply(), .storageHigh(),
    .sfLoad(), .sampleXfer(), .integrating(), .dcRefLevel(dcRefLevel), .dualOutput(dualOutput),
    .flushDone(flushDone));

  pac_ctrl_model pac_ctrl_model_i (.mclk(mclk), .srst(srst), .pinReq(pinReq),
    .flushSent(flushSent), .fullResetCtrl(fullResetCtrl), .partial_reset_ctrl(partial_reset_ctrl),
    .prechargeCtrlN(prechargeCtrlN), .sampleCtrlN(sampleCtrlN),
    .storage_boost_ctrl(storage_boost_ctrl), .colClk(colClk), .rowClk(rowClk));

  task close_out();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Only reads carry a data mask; every transfer carries its expected error flag.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] dat, input logic [31:0] m,
    input logic e);
    expQ.push_back(dat & m);
    mskQ.push_back(m);
    errQ.push_back(e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task set_pins(input logic [4:0] p);
    @(posedge mclk);
    pinReq <= p;
    repeat (5) @(posedge mclk);
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      close_out();
    end
    else if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      chk(prdata & mskQ[0], expQ[0]);
      chk({31'h0, pslverr}, {31'h0, errQ[0]});
      void'(expQ.pop_front());
      void'(mskQ.pop_front());
      void'(errQ.pop_front());
    end
  end

  initial
  begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    apb(1'b0, pac_pkg::STAT_ADDR, 32'h00000000, 32'h00000080, 1'b0);
    for (i = 0; i < 3; i++)
    begin
      d = $random(seed);
      apb(1'b1, pac_pkg::CFG_ADDR, d, 32'h00000000, 1'b0);
      apb(1'b0, pac_pkg::CFG_ADDR, d, 32'h000000ff, 1'b0);
      chk({24'h0, dualOutput, dcRefLevel}, {24'h0, d[7:0]});
    end
    apb(1'b1, pac_pkg::STAT_ADDR, 32'hffffffff, 32'h00000000, 1'b0);
    apb(1'b0, 8'h0c, 32'h00000000, 32'hffffffff, 1'b1);
    for (i = 0; i < 32; i++)
    begin
      set_pins(i[4:0]);
      d = {26'h0, i[0], i[4], ~i[3], ~i[2], i[1] & ~i[0], i[0] | i[1]};
      apb(1'b0, pac_pkg::STAT_ADDR, d, 32'h0000003f, 1'b0);
    end
    set_pins(5'h1d);
    set_pins(5'h1c);
    apb(1'b0, pac_pkg::STAT_ADDR, 32'h00000040, 32'h00000041, 1'b0);
    set_pins(5'h1e);
    apb(1'b0, pac_pkg::STAT_ADDR, 32'h00000043, 32'h00000063, 1'b0);
    set_pins(5'h04);
    apb(1'b0, pac_pkg::STAT_ADDR, 32'h00000008, 32'h00000049, 1'b0);
    // Counted frame: six cycles per step, so release to sample spans 42 cycles.
    set_pins(5'h1d);
    set_pins(5'h1c);
    for (i = 0; i < 2; i++)
    begin
      set_pins(5'h1e);
      set_pins(5'h1c);
    end
    set_pins(5'h0c);
    set_pins(5'h08);
    set_pins(5'h00);
    set_pins(5'h04);
    set_pins(5'h0c);
    set_pins(5'h1c);
    apb(1'b0, pac_pkg::CNT_ADDR, 32'h0000002a, 32'hffffffff, 1'b0);
    while (flushSent !== 1'b1)
      @(posedge mclk);
    repeat (5) @(posedge mclk);
    chk({31'h0, flushDone}, 32'h00000001);
    apb(1'b0, pac_pkg::STAT_ADDR, 32'h00000080, 32'h00000080, 1'b0);
    close_out();
  end
endmodule
